// *** design/pse_is_consts.svh ***
// Constants of the interrupt summary block: command codes, field positions, reset values.
// Assumes it is included by bare name into the design module; the package does not include it.
`ifndef PSE_IS_CONSTS_SVH
`define PSE_IS_CONSTS_SVH

`define PSE_IS_CMD_SUMMARY 8'h00
`define PSE_IS_CMD_MASK 8'h01
`define PSE_IS_CMD_PWR_EVT 8'h02
`define PSE_IS_CMD_PWR_EVT_CLR 8'h03
`define PSE_IS_CMD_DET_EVT_CLR 8'h05
`define PSE_IS_CMD_FLT_EVT_CLR 8'h07
`define PSE_IS_CMD_ILIM_EVT_CLR 8'h09
`define PSE_IS_CMD_SUP_EVT_CLR 8'h0B
`define PSE_IS_CMD_RESET 8'h1A
`define PSE_IS_CMD_GEN_MASK 8'h17

`define PSE_IS_BIT_SUPPLY 7
`define PSE_IS_BIT_START 6
`define PSE_IS_BIT_OVERCUR 5
`define PSE_IS_BIT_CLASS 4
`define PSE_IS_BIT_DETECT 3
`define PSE_IS_BIT_DISC 2
`define PSE_IS_BIT_PGOOD 1
`define PSE_IS_BIT_PENABLE 0
`define PSE_IS_BIT_CLR_ALL 7
`define PSE_IS_BIT_GLOBAL_IRQ_ENABLE 7

`define PSE_IS_SUMMARY_RST 8'h80
`define PSE_IS_MASK_RST 8'h80
`define PSE_IS_GLOBAL_IRQ_ENABLE_RST 1'h0

`endif

// *** design/pse_is_pkg.sv ***
// Types shared by the interrupt summary block and its surroundings.
// Assumes the event logic and the command decoder share the block's clock.
package pse_is_pkg;

  // Supply-level event flags
  typedef struct packed {
    logic thermal_shutdown;
    logic digital_supply_undervolt;
    logic digital_supply_warning;
    logic power_supply_undervolt;
    logic sram_fault;
  } pse_is_supply_t;

  // Per-channel event flags, one bit per channel
  typedef struct packed {
    logic [3:0] chan_start_timeout;
    logic [3:0] chan_overload_timeout;
    logic [3:0] chan_current_limit_timeout;
    logic [3:0] chan_class_done;
    logic [3:0] chan_detect_done;
    logic [3:0] chan_disconnect;
    logic [3:0] chan_power_good_change;
    logic [3:0] chan_power_enable_change;
  } pse_is_chan_t;

  // One register command from the serial front end
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } pse_is_req_t;

endpackage

// *** design/pse_is_summary.sv ***
// Interrupt summary: sticky summary byte, mask, global enable and active-low interrupt.
// Assumes event flags and commands arrive on clk from same-domain logic.
`timescale 1ns/1ps
`include "pse_is_consts.svh"

module pse_is_summary
  import pse_is_pkg::*;
(
  input wire logic clk, // 250 MHz device clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic ce, // Clock enable, freezes state when low
  input wire pse_is_supply_t supply_evt, // Supply-level event flags
  input wire pse_is_chan_t chan_evt, // Per-channel event flags
  input wire pse_is_req_t req, // Register command
  output logic [7:0] rdata, // Read data, valid with rvalid
  output logic rvalid, // Read data valid, one cycle
  output logic int_n // Interrupt output, active low
);

  logic [7:0] sum_q;
  logic [7:0] sum_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic global_irq_enable_q;
  logic global_irq_enable_d;
  logic int_n_q;
  logic int_n_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic clr_all;
  logic rd_go;
  logic wr_go;

  assign rd_go = req.rd;
  assign wr_go = req.wr;

  // Event sources of each summary bit
  assign set_vec[`PSE_IS_BIT_SUPPLY] = |supply_evt;
  assign set_vec[`PSE_IS_BIT_START] = |chan_evt.chan_start_timeout;
  assign set_vec[`PSE_IS_BIT_OVERCUR] = |{chan_evt.chan_overload_timeout,
                                          chan_evt.chan_current_limit_timeout};
  assign set_vec[`PSE_IS_BIT_CLASS] = |chan_evt.chan_class_done;
  assign set_vec[`PSE_IS_BIT_DETECT] = |chan_evt.chan_detect_done;
  assign set_vec[`PSE_IS_BIT_DISC] = |chan_evt.chan_disconnect;
  assign set_vec[`PSE_IS_BIT_PGOOD] = |chan_evt.chan_power_good_change;
  assign set_vec[`PSE_IS_BIT_PENABLE] = |chan_evt.chan_power_enable_change;

  // Clear-on-read decode; the read-only power event code clears nothing
  always_comb
  begin
    clr_vec = 8'h00;
    if (rd_go)
    begin
      case (req.cmd)
        `PSE_IS_CMD_PWR_EVT_CLR:
        begin
          clr_vec[`PSE_IS_BIT_PGOOD] = 1'b1;
          clr_vec[`PSE_IS_BIT_PENABLE] = 1'b1;
        end
        `PSE_IS_CMD_DET_EVT_CLR:
        begin
          clr_vec[`PSE_IS_BIT_CLASS] = 1'b1;
          clr_vec[`PSE_IS_BIT_DETECT] = 1'b1;
        end
        `PSE_IS_CMD_FLT_EVT_CLR:
        begin
          clr_vec[`PSE_IS_BIT_START] = 1'b1;
          clr_vec[`PSE_IS_BIT_DISC] = 1'b1;
        end
        `PSE_IS_CMD_ILIM_EVT_CLR:
        begin
          clr_vec[`PSE_IS_BIT_OVERCUR] = 1'b1;
        end
        `PSE_IS_CMD_SUP_EVT_CLR:
        begin
          clr_vec[`PSE_IS_BIT_SUPPLY] = 1'b1;
        end
        default:
        begin
          clr_vec = 8'h00;
        end
      endcase
    end
  end

  assign clr_all = wr_go && (req.cmd == `PSE_IS_CMD_RESET) &&
                   req.wdata[`PSE_IS_BIT_CLR_ALL];

  // Sticky summary bits; an event in the clearing cycle keeps its bit set
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_sum
      assign sum_d[gi] = set_vec[gi] | (sum_q[gi] & ~clr_vec[gi] & ~clr_all);
    end
  endgenerate

  // Control registers and read path
  always_comb
  begin
    mask_d = mask_q;
    global_irq_enable_d = global_irq_enable_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    if (wr_go && (req.cmd == `PSE_IS_CMD_MASK))
    begin
      mask_d = req.wdata;
    end
    if (wr_go && (req.cmd == `PSE_IS_CMD_GEN_MASK))
    begin
      global_irq_enable_d = req.wdata[`PSE_IS_BIT_GLOBAL_IRQ_ENABLE];
    end
    if (rd_go)
    begin
      rvalid_d = 1'b1;
      case (req.cmd)
        `PSE_IS_CMD_SUMMARY: rdata_d = sum_q;
        `PSE_IS_CMD_MASK: rdata_d = mask_q;
        `PSE_IS_CMD_GEN_MASK: rdata_d = {global_irq_enable_q, 7'h00};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Masked, enabled summary drives the interrupt low
  always_comb
  begin
    int_n_d = ~(global_irq_enable_q && |(sum_q & mask_q));
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sum_q <= `PSE_IS_SUMMARY_RST;
      mask_q <= `PSE_IS_MASK_RST;
      global_irq_enable_q <= `PSE_IS_GLOBAL_IRQ_ENABLE_RST;
      int_n_q <= 1'b1;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else if (ce)
    begin
      sum_q <= sum_d;
      mask_q <= mask_d;
      global_irq_enable_q <= global_irq_enable_d;
      int_n_q <= int_n_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign rdata = rdata_q;
  assign rvalid = rvalid_q;
  assign int_n = int_n_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sum_set_a: assert property (ce |=> ((sum_q & $past(set_vec)) == $past(set_vec)))
    else $error("summary bit missed an event");
  sum_sticky_a: assert property (ce && !clr_all && (clr_vec == 8'h00)
      |=> ((($past(sum_q)) & ~sum_q) == 8'h00))
    else $error("summary bit fell without a clear");
  clear_all_a: assert property (ce && clr_all |=> (sum_q == $past(set_vec)))
    else $error("reset bit did not clear summary");
  pwr_evt_clr_a: assert property (ce && rd_go && (req.cmd == `PSE_IS_CMD_PWR_EVT_CLR)
      && (set_vec[1:0] == 2'b00) |=> (sum_q[1:0] == 2'b00))
    else $error("power event clear read kept bits");
  pwr_evt_ro_a: assert property (ce && rd_go && (req.cmd == `PSE_IS_CMD_PWR_EVT)
      |=> (sum_q[1:0] == ($past(sum_q[1:0]) | $past(set_vec[1:0]))))
    else $error("plain power event read changed summary");
  irq_on_a: assert property (ce && global_irq_enable_q && |(sum_q & mask_q) |=> !int_n)
    else $error("interrupt not asserted");
  irq_off_a: assert property (ce && !(global_irq_enable_q && |(sum_q & mask_q)) |=> int_n)
    else $error("interrupt not released");
  mask_block_a: assert property (ce && (mask_q == 8'h00) ##1 ce && (mask_q == 8'h00)
      |=> int_n)
    else $error("masked summary drove interrupt");
  sum_read_a: assert property (ce && rd_go && (req.cmd == `PSE_IS_CMD_SUMMARY)
      |=> rvalid && (rdata == $past(sum_q)))
    else $error("summary read returned wrong byte");
  sum_ro_a: assert property (ce && wr_go && (req.cmd == `PSE_IS_CMD_SUMMARY)
      && !rd_go && (set_vec == 8'h00) |=> (sum_q == $past(sum_q)))
    else $error("write altered summary");
  freeze_a: assert property (!ce |=> $stable(sum_q) && $stable(mask_q) && $stable(int_n))
    else $error("state moved with clock enable low");
  reset_val_a: assert property (disable iff (1'b0) rst |=> (sum_q == `PSE_IS_SUMMARY_RST)
      && int_n && (mask_q == `PSE_IS_MASK_RST))
    else $error("wrong reset values");

  irq_seen_c: cover property (ce && !int_n ##1 int_n);
  clr_race_c: cover property (ce && rd_go && |(clr_vec & set_vec));
  clear_all_c: cover property (ce && clr_all && (sum_q != 8'h00));
  masked_evt_c: cover property (ce && |(sum_q & ~mask_q) && int_n);

endmodule

// *** dv/pse_interrupt_summary_test.sv ***
// Testbench of the interrupt summary: bit mapping, clears, mask and interrupt line.
// Assumes the package, the host model and the design are compiled first.
`timescale 1ns/1ps

module pse_interrupt_summary_test;
  import pse_is_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  pse_is_supply_t supply_evt = '0;
  pse_is_chan_t chan_evt = '0;
  pse_is_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  logic int_n;
  int failures = 0;
  int checked = 0;
  logic [7:0] d;
  logic ok;
  // Summary bit and clear code of each channel field, msb field first
  int fbit[8] = '{6, 5, 5, 4, 3, 2, 1, 0};
  logic [7:0] fclr[8] = '{8'h07, 8'h09, 8'h09, 8'h05, 8'h05, 8'h07, 8'h03, 8'h03};

  always #2 clk = ~clk;

  pse_is_summary pse_is_summary_i (.clk(clk), .rst(rst), .ce(ce), .supply_evt(supply_evt),
    .chan_evt(chan_evt), .req(req), .rdata(rdata), .rvalid(rvalid), .int_n(int_n));
  pse_is_host pse_is_host_i (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid),
    .int_n(int_n));

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
    pse_is_host_i.rd(cmd, d, ok);
    chk("rvalid", 8'h01, {7'h00, ok});
    chk("rdata", exp, d);
  endtask

  task automatic pulse(input logic [4:0] s, input logic [31:0] c);
    @(posedge clk);
    supply_evt <= s;
    chan_evt <= c;
    @(posedge clk);
    supply_evt <= '0;
    chan_evt <= '0;
  endtask

  task automatic irq_chk(input logic exp);
    repeat (3) @(posedge clk);
    pse_is_host_i.irq(ok);
    chk("int_n", {7'h00, exp}, {7'h00, ok});
  endtask

  task automatic test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    test_done();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_chk(8'h00, 8'h80);
    rd_chk(8'h01, 8'h80);
    rd_chk(8'h17, 8'h00);
    irq_chk(1'b1);
    pse_is_host_i.wr(8'h1A, 8'h80);
    rd_chk(8'h00, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 5; i++)
    begin
      pulse(5'h01 << i, '0);
      rd_chk(8'h00, 8'h80);
      pse_is_host_i.rd(8'h0B, d, ok);
      rd_chk(8'h00, 8'h00);
    end
    for (int k = 0; k < 8; k++)
    begin
      pulse('0, 32'h1 << (28 - 4 * k + k % 4));
      rd_chk(8'h00, 8'h01 << fbit[k]);
      pse_is_host_i.rd(fclr[k], d, ok);
      rd_chk(8'h00, 8'h00);
    end
    $display("test mapping done");
    pse_is_host_i.wr(8'h01, 8'h04);
    pse_is_host_i.wr(8'h17, 8'h80);
    rd_chk(8'h01, 8'h04);
    rd_chk(8'h17, 8'h80);
    pulse('0, 32'h1 << 10);
    irq_chk(1'b0);
    pse_is_host_i.wr(8'h01, 8'h00);
    irq_chk(1'b1);
    rd_chk(8'h00, 8'h04);
    pse_is_host_i.wr(8'h01, 8'h04);
    irq_chk(1'b0);
    pse_is_host_i.wr(8'h17, 8'h00);
    irq_chk(1'b1);
    pse_is_host_i.wr(8'h17, 8'h80);
    irq_chk(1'b0);
    pse_is_host_i.rd(8'h07, d, ok);
    irq_chk(1'b1);
    pse_is_host_i.wr(8'h00, 8'hFF);
    rd_chk(8'h00, 8'h00);
    $display("test mask done");
    pse_is_host_i.wr(8'h01, 8'h02);
    pulse('0, 32'h1 << 7);
    irq_chk(1'b0);
    pse_is_host_i.rd(8'h02, d, ok);
    rd_chk(8'h00, 8'h02);
    pse_is_host_i.rd(8'h03, d, ok);
    irq_chk(1'b1);
    rd_chk(8'h00, 8'h00);
    $display("test power event done");
    // An event seen only while the clock enable is low must leave no trace
    @(posedge clk);
    ce <= 1'b0;
    pulse('0, 32'h1 << 7);
    ce <= 1'b1;
    rd_chk(8'h00, 8'h00);
    $display("test clock enable done");
    test_done();
  end
endmodule

// *** dv/pse_is_host.sv ***
// Host model: issues single-byte register commands to the summary block.
// Assumes it shares clk with the block; a bench calls its tasks.
`timescale 1ns/1ps

module pse_is_host
  import pse_is_pkg::*;
(
  input wire logic clk, // Device clock
  output pse_is_req_t req, // Register command
  input wire logic [7:0] rdata, // Read data
  input wire logic rvalid, // Read data valid
  input wire logic int_n // Interrupt, active low
);
  initial req = '0;

  // Idle command fields show inverted stale values
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data);
    @(posedge clk);
    req <= '{1'b0, 1'b1, cmd, data};
    @(posedge clk);
    req <= '{1'b0, 1'b0, ~cmd, ~data};
  endtask

  // Data is taken while rvalid stands; clearing is done by reading
  task automatic rd(input logic [7:0] cmd, output logic [7:0] data, output logic ok);
    @(posedge clk);
    req <= '{1'b1, 1'b0, cmd, 8'h00};
    @(posedge clk);
    req <= '{1'b0, 1'b0, ~cmd, 8'hFF};
    @(negedge clk);
    data = rdata;
    ok = rvalid;
  endtask

  // Interrupt line as the host sees it, between clock edges
  task automatic irq(output logic level);
    @(negedge clk);
    level = int_n;
  endtask
endmodule
